/* File: accw_map.svh */
`ifndef ACCW_MAP_SVH
`define ACCW_MAP_SVH
// Contract
// [R1] Register writes accepted only in software mode; values kept in hardware mode.
// [R2] Stored values never follow configuration pin levels.
// [R3] Parallel write takes effect at rising edge of write strobe.
// [R4] Serial write takes effect on 32nd falling serial clock edge.
// [R5] Partial serial update writes bits 31..24 only, lower bits kept.
// [R6] Default value has ten lowest bits one, all others zero.
// [R7] Bits 31..29 enable pairs C, B, A; default disabled.
// [R8] Bits 28..26 pick range of pairs C, B, A; 0 is four times reference.
// [R9] Bit 25 enables internal reference; bit 24 set disables reference buffers.
// [R10] Bit 23 enables interleaved start; host must also set bit 11.
// [R11] Bit 22 enables auto nap; stays effective in hardware mode.
// [R12] Bit 21 selects status pin function: busy or interrupt.
// [R13] Bit 20 selects status pin polarity: high or low active.
// [R14] Bits 19 and 12 unused, written zero, treated as zero.
// [R15] Bit 18 selects internal reference voltage 2.5 V or 3 V.
// [R16] Bit 17 makes next serial access shift out register, not results.
// [R17] Bit 16 sets serial write scope: upper byte only or whole word.
// [R18] Bits 15..13 power down pairs C, B, A; host keeps enable zero.
// [R19] Bit 11 selects external conversion clock; host keeps internal in hardware mode.
// [R20] Bit 10 drives internal conversion clock onto the shared clock pin.
// [R21] Bits 9..0 hold reference DAC code, MSB bit 9, default ones.
// [R22] Hardware mode ignores bits 31..23, 11, 10; others stay in effect.
// [R23] Host supplies register data with every serial read; init with full update.
// [R24] Power-on or pin reset aborts conversion and restores default value; conv_abort is raised by pin reset only.
// [R25] Register contents retained unchanged during standby.
`define ACCW_DEFAULT     32'h0000_03ff
`define ACCW_ZERO_MASK   32'h0008_1000
`define ACCW_HW_MASK     32'h0077_e3ff
`define ACCW_UPPER_MASK  32'hff00_0000
`define ACCW_FULL_BIT    16
`define ACCW_READ_BIT    17
`define ACCW_FRAME_BITS  6'h20
`define ACCW_CNT_LAST    6'h1f
`endif

/* File: accw_pkg.sv */
package accw_pkg;
	// Decoded control fields
	typedef struct packed {
		logic [2:0] pair_enable;
		logic [2:0] range_2x;
		logic       internal_ref_on;
		logic       ref_buffer_off;
		logic       interleaved_start;
		logic       auto_nap;
		logic       status_int_mode;
		logic       status_active_low;
		logic       ref_3v;
		logic       readback;
		logic       full_update_enable;
		logic [2:0] pair_powerdown;
		logic       conv_clock_source;
		logic       conv_clock_output;
		logic [9:0] ref_dac_code;
	} accw_fields_t;
	// Serial receive states
	typedef enum logic [1:0] {
		ACCW_IDLE  = 2'b01,
		ACCW_SHIFT = 2'b10
	} accw_state_t;
endpackage

/* File: accw_ctrl.sv */
`timescale 1ns/1ps
`include "accw_map.svh"
module accw_ctrl
	import accw_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         clk_en,
	// Device pins
	input  wire logic         pin_reset,
	input  wire logic         sw_mode,
	input  wire logic         serial_mode,
	input  wire logic         standby_pin_n,
	// Parallel port
	input  wire logic         wr_n,
	input  wire logic [31:0]  par_data,
	// Serial port
	input  wire logic         cs_n,
	input  wire logic         sclk,
	input  wire logic         sdi,
	output logic              sdo,
	// Register view
	output logic [31:0]       converter_control_word,
	output accw_fields_t      fields,
	output logic              conv_abort
);
	// ************************************************
	// Input synchronisers
	// ************************************************
	logic [1:0] s1_q, s2_q, s3_q, s4_q, s5_q, s6_q, s7_q, s8_q;
	logic [31:0] p1_q, p2_q;
	logic wr_n_d1_q, sclk_d1_q, cs_d1_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			s3_q <= 2'h0; // Serial clock idles low: no false edge
			s4_q <= 2'h0;
			s5_q <= 2'h0;
			s6_q <= 2'h0;
			s7_q <= 2'h0;
			s8_q <= 2'h3;
			p1_q <= 32'h0;
			p2_q <= 32'h0;
		end else if (clk_en) begin
			s1_q <= {s1_q[0], wr_n};
			s2_q <= {s2_q[0], cs_n};
			s3_q <= {s3_q[0], sclk};
			s4_q <= {s4_q[0], sdi};
			s5_q <= {s5_q[0], pin_reset};
			s6_q <= {s6_q[0], sw_mode};
			s7_q <= {s7_q[0], serial_mode};
			s8_q <= {s8_q[0], standby_pin_n};
			p1_q <= par_data;
			p2_q <= p1_q;
		end
	end
	wire wr_s   = s1_q[1];
	wire cs_s   = s2_q[1];
	wire sclk_s = s3_q[1];
	wire sdi_s  = s4_q[1];
	wire rst_s  = s5_q[1];
	wire sw_s   = s6_q[1];
	wire ser_s  = s7_q[1];
	// Standby is only watched; the word must not react to it
	wire standby_pin_n_s = s8_q[1];

	// Edge detectors on synchronised copies only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_n_d1_q <= 1'b1;
			sclk_d1_q <= 1'b0;
			cs_d1_q   <= 1'b1;
		end else if (clk_en) begin
			wr_n_d1_q <= wr_s;
			sclk_d1_q <= sclk_s;
			cs_d1_q   <= cs_s;
		end
	end
	wire wr_rise   = wr_s & ~wr_n_d1_q;
	wire sclk_fall = ~sclk_s & sclk_d1_q;
	wire sclk_rise = sclk_s & ~sclk_d1_q;
	wire cs_fall   = ~cs_s & cs_d1_q;

	// ************************************************
	// Serial receive and readback shift
	// ************************************************
	accw_state_t state_q, state_d;
	logic [5:0]  cnt_q;
	logic [31:0] rx_q, tx_q;
	logic        rd_sel_q;
	logic [31:0] cw_q;
	wire last_fall = (state_q == ACCW_SHIFT) && sclk_fall && !cs_s
		&& (cnt_q == `ACCW_CNT_LAST);
	wire [31:0] rx_word = {rx_q[30:0], sdi_s};

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ACCW_IDLE: begin
				if (cs_fall && ser_s)
					state_d = ACCW_SHIFT;
			end
			ACCW_SHIFT: begin
				if (cs_s || last_fall)
					state_d = ACCW_IDLE;
			end
		endcase
	end

	// Data sampled on falling serial clock, MSB first
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q  <= ACCW_IDLE;
			cnt_q    <= 6'h0;
			rx_q     <= 32'h0;
			tx_q     <= 32'h0;
			rd_sel_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			if (cs_fall) begin
				cnt_q    <= 6'h0;
				rd_sel_q <= cw_q[`ACCW_READ_BIT]; // [R16]
				tx_q     <= cw_q;
			end else if (state_q == ACCW_SHIFT && sclk_fall) begin
				rx_q  <= rx_word;
				// Shift after the fall so bit 31 stands for the first read
				tx_q  <= {tx_q[30:0], 1'b0}; // [R16]
				cnt_q <= cnt_q + 6'h1;
			end
		end
	end
	// Conversion data path lies outside; only readback is driven here
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			sdo <= 1'b0;
		else if (clk_en)
			sdo <= rd_sel_q & tx_q[31]; // [R16]
	end

	// ************************************************
	// Control word commit
	// ************************************************
	// Scope picks whole word or upper byte only
	wire [31:0] ser_mask = cw_q[`ACCW_FULL_BIT] ? 32'hffff_ffff
		: `ACCW_UPPER_MASK; // [R5] [R17]
	wire [31:0] ser_new  = (rx_word & ser_mask) | (cw_q & ~ser_mask);
	wire ser_commit = sw_s && ser_s && last_fall; // [R1] [R4] [R23]
	wire par_commit = sw_s && !ser_s && wr_rise;  // [R1] [R3]
	wire [31:0] cw_d = ser_commit ? ser_new
		: par_commit ? p2_q : cw_q;

	// Only the strobes and the reset pin load it; other pins and standby never touch it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cw_q <= `ACCW_DEFAULT;                    // [R6] [R24]
		else if (clk_en) begin
			if (rst_s)
				cw_q <= `ACCW_DEFAULT;                // [R24]
			else
				cw_q <= cw_d & ~`ACCW_ZERO_MASK;      // [R2] [R14] [R25]
		end
	end
	assign converter_control_word = cw_q;
	assign conv_abort = rst_s; // [R24]

	// ************************************************
	// Effective fields
	// ************************************************
	// Hardware mode drops the software-only bits to their idle value
	wire [31:0] eff = sw_s ? cw_q : (cw_q & `ACCW_HW_MASK); // [R22]
	assign fields.pair_enable        = eff[31:29]; // [R7]
	assign fields.range_2x           = eff[28:26]; // [R8]
	assign fields.internal_ref_on    = eff[25];    // [R9]
	assign fields.ref_buffer_off     = eff[24];    // [R9]
	assign fields.interleaved_start  = eff[23];    // [R10]
	assign fields.auto_nap           = eff[22];    // [R11]
	assign fields.status_int_mode    = eff[21];    // [R12]
	assign fields.status_active_low  = eff[20];    // [R13]
	assign fields.ref_3v             = eff[18];    // [R15]
	assign fields.readback           = eff[17];    // [R16]
	assign fields.full_update_enable = eff[16];    // [R17]
	assign fields.pair_powerdown     = eff[15:13]; // [R18]
	assign fields.conv_clock_source  = eff[11];    // [R19]
	assign fields.conv_clock_output  = eff[10];    // [R20]
	assign fields.ref_dac_code       = eff[9:0];   // [R21]

	// ************************************************
	// Assertions
	// ************************************************
	property p_default;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && rst_s) |=> (cw_q == `ACCW_DEFAULT);
	endproperty
	a_default: assert property (p_default) else $error("no default"); // [R24]
	property p_hwhold;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && !sw_s && !rst_s) |=> (cw_q == $past(cw_q));
	endproperty
	a_hwhold: assert property (p_hwhold) else $error("hw write"); // [R1]
	property p_zero;
		@(posedge clk) disable iff (!arst_n)
		(cw_q & `ACCW_ZERO_MASK) == 32'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("unused bit set"); // [R14]
	property p_partial;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && ser_commit && !cw_q[`ACCW_FULL_BIT] && !rst_s)
		|=> (cw_q[23:0] == $past(cw_q[23:0]));
	endproperty
	a_partial: assert property (p_partial) else $error("low bits hit"); // [R5]
	property p_par;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && par_commit && !rst_s)
		|=> (cw_q == ($past(p2_q) & ~`ACCW_ZERO_MASK));
	endproperty
	a_par: assert property (p_par) else $error("parallel miss"); // [R3]
	property p_hwmask;
		@(posedge clk) disable iff (!arst_n)
		!sw_s |-> (fields.pair_enable == 3'h0 && !fields.conv_clock_source);
	endproperty
	a_hwmask: assert property (p_hwmask) else $error("hw mask"); // [R22]
	property p_stable;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && !ser_commit && !par_commit && !rst_s)
		|=> (cw_q == $past(cw_q));
	endproperty
	a_stable: assert property (p_stable) else $error("spurious"); // [R2]
	property p_dac;
		@(posedge clk) disable iff (!arst_n)
		fields.ref_dac_code == cw_q[9:0];
	endproperty
	a_dac: assert property (p_dac) else $error("dac code"); // [R21]

	// ************************************************
	// Assertions on serial framing and field gating
	// ************************************************
	// A serial commit is the counted last fall of a software frame
	sequence s_ser_commit;
		clk_en && ser_commit && !rst_s;
	endsequence
	// Same commit while the stored scope bit allows the whole word
	sequence s_full_commit;
		clk_en && ser_commit && !rst_s && cw_q[`ACCW_FULL_BIT];
	endsequence
	property p_ser_commit;
		@(posedge clk) disable iff (!arst_n)
		s_ser_commit |=> (cw_q == ($past(ser_new) & ~`ACCW_ZERO_MASK));
	endproperty
	a_ser_commit: assert property (p_ser_commit) // [R4]
		else $error("serial miss");
	property p_full;
		@(posedge clk) disable iff (!arst_n)
		s_full_commit |=> (cw_q == ($past(rx_word) & ~`ACCW_ZERO_MASK));
	endproperty
	a_full: assert property (p_full) // [R17]
		else $error("full update miss");

	// Frame start latches the readback choice from the stored word
	sequence s_frame_start;
		clk_en && cs_fall;
	endsequence
	property p_rd_sel;
		@(posedge clk) disable iff (!arst_n)
		s_frame_start |=> (rd_sel_q == $past(cw_q[`ACCW_READ_BIT]));
	endproperty
	a_rd_sel: assert property (p_rd_sel) // [R16]
		else $error("readback select");
	// Without readback the serial output stays low
	property p_sdo_low;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && !rd_sel_q) |=> !sdo;
	endproperty
	a_sdo_low: assert property (p_sdo_low) // [R16]
		else $error("sdo not low");
	// The output word only moves after a fall, so the host sees it settled
	property p_tx_hold;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && sclk_rise && !cs_fall) |=> (tx_q == $past(tx_q));
	endproperty
	a_tx_hold: assert property (p_tx_hold) // [R16]
		else $error("tx moved on rise");

	// A held reset pin keeps the default in place
	sequence s_rst_held;
		(clk_en && rst_s) ##1 (clk_en && rst_s);
	endsequence
	property p_rst_held;
		@(posedge clk) disable iff (!arst_n)
		s_rst_held |-> (cw_q == `ACCW_DEFAULT);
	endproperty
	a_rst_held: assert property (p_rst_held) // [R24]
		else $error("reset not held");
	// Standby leaves the stored word alone
	property p_standby;
		@(posedge clk) disable iff (!arst_n)
		(clk_en && !standby_pin_n_s && !ser_commit && !par_commit && !rst_s)
		|=> (cw_q == $past(cw_q));
	endproperty
	a_standby: assert property (p_standby) // [R25]
		else $error("standby change");

	// Gated fields read zero in hardware mode
	property p_hw_gate;
		@(posedge clk) disable iff (!arst_n)
		!sw_s |-> (fields.range_2x == 3'h0 && !fields.internal_ref_on
			&& !fields.ref_buffer_off && !fields.interleaved_start
			&& !fields.conv_clock_output);
	endproperty
	a_hw_gate: assert property (p_hw_gate) // [R22]
		else $error("hw gate");
	// Kept fields pass straight through in either mode
	property p_hw_keep;
		@(posedge clk) disable iff (!arst_n)
		(fields.auto_nap == cw_q[22])
		&& (fields.pair_powerdown == cw_q[15:13]);
	endproperty
	a_hw_keep: assert property (p_hw_keep) // [R11] [R18]
		else $error("kept field lost");
	// Software mode shows the stored enables unmasked
	property p_sw_pass;
		@(posedge clk) disable iff (!arst_n)
		sw_s |-> (fields.pair_enable == cw_q[31:29]);
	endproperty
	a_sw_pass: assert property (p_sw_pass) // [R7]
		else $error("enable masked");

	// A frame never counts past its last bit
	property p_cnt;
		@(posedge clk) disable iff (!arst_n)
		(state_q == ACCW_SHIFT) |-> (cnt_q <= `ACCW_CNT_LAST);
	endproperty
	a_cnt: assert property (p_cnt) // [R4]
		else $error("bit count overrun");
	// Receive state stays one-hot
	property p_onehot;
		@(posedge clk) disable iff (!arst_n)
		$onehot(state_q);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("state code");
	// Low enable freezes the word and the frame state
	property p_freeze;
		@(posedge clk) disable iff (!arst_n)
		!clk_en |=> (cw_q == $past(cw_q) && state_q == $past(state_q)
			&& cnt_q == $past(cnt_q));
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while frozen");
endmodule

/* File: accw_host.sv */
`timescale 1ns/1ps
// ****************
// Host model
// ****************
module accw_host (
	// Clock and register view
	input  wire logic        clk,
	input  wire logic        sdo,
	input  wire logic [31:0] cw,
	// Parallel port
	output logic             wr_n,
	output logic [31:0]      par_data,
	// Serial port
	output logic             cs_n,
	output logic             sclk,
	output logic             sdi
);
	logic [31:0] pre;
	logic [31:0] rd;
	// Idle levels; sclk stands low outside frames
	initial begin
		wr_n = 1'b1;
		par_data = 32'h0;
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Strobe held long enough for the synchroniser; pre is the old word
	task automatic par_write(input logic [31:0] w);
		par_data = w;
		tick(2);
		wr_n = 1'b0;
		tick(6);
		pre = cw;
		wr_n = 1'b1;
		tick(4);
		par_data = ~w; // Released bus must not look stale
	endtask
	// Word goes out MSB first; pre is taken before the last fall
	task automatic frame(input logic [31:0] w, input int n);
		cs_n = 1'b0;
		rd = 32'h0;
		tick(4);
		for (int i = 31; i > 31 - n; i--) begin
			sclk = 1'b1;
			sdi = w[i];
			tick(4);
			pre = cw;
			rd = {rd[30:0], sdo};
			sclk = 1'b0;
			tick(4);
		end
		sdi = ~sdi;
		cs_n = 1'b1;
		tick(6);
	endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
`include "accw_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t value %h expected %h", $time, (a), (b)); end end
// ****************
// Testbench
// ****************
module tb
	import accw_pkg::*;
;
	logic clk, arst_n, pin_reset, sw_mode, serial_mode, standby_pin_n;
	logic clk_en;
	logic wr_n, cs_n, sclk, sdi, sdo, conv_abort;
	logic [31:0] par_data, cw;
	accw_fields_t fields;
	int err_count = 0;
	int compares = 0;
	localparam logic [31:0] B = 32'h2041_87c0;
	accw_ctrl u_accw_ctrl (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
		.pin_reset(pin_reset), .sw_mode(sw_mode), .serial_mode(serial_mode),
		.standby_pin_n(standby_pin_n), .wr_n(wr_n), .par_data(par_data),
		.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
		.converter_control_word(cw), .fields(fields),
		.conv_abort(conv_abort));
	accw_host u_accw_host (.clk(clk), .sdo(sdo), .cw(cw), .wr_n(wr_n),
		.par_data(par_data), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Fields drop the two unused bits of the word
	function automatic accw_fields_t view(input logic [31:0] m);
		return accw_fields_t'({m[31:20], m[18:13], m[11:0]});
	endfunction
	task automatic complete_run();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Cuts a hang short well after the expected 16 us
	initial begin
		#200000;
		err_count++;
		complete_run();
	end
	task automatic t_serial();
		u_accw_host.frame(32'ha5ff_ffff, 32);
		`CHK(u_accw_host.pre, `ACCW_DEFAULT)
		`CHK(cw, 32'ha500_03ff)
		`CHK(u_accw_host.rd, 32'h0)
	endtask
	task automatic t_parallel();
		serial_mode = 1'b0;
		u_accw_host.tick(4);
		u_accw_host.par_write(32'h1afd_1aaa);
		`CHK(u_accw_host.pre, 32'ha500_03ff)
		`CHK(cw, 32'h1af5_0aaa)
		serial_mode = 1'b1;
		u_accw_host.tick(4);
		u_accw_host.frame(B, 32);
		`CHK(cw, B)
		`CHK(fields, view(B))
		u_accw_host.frame(B | 32'h0082_0800, 32);
		`CHK(fields.interleaved_start, 1'b1)
		`CHK(fields.conv_clock_source, 1'b1)
		`CHK(fields.readback, 1'b1)
		u_accw_host.frame(B, 32);
		`CHK(u_accw_host.rd, B | 32'h0082_0800)
		`CHK(cw, B)
		u_accw_host.frame(32'h0, 16);
		`CHK(cw, B)
	endtask
	// Writes, pin and standby changes while in hardware mode
	task automatic t_hw();
		sw_mode = 1'b0;
		u_accw_host.tick(4);
		`CHK(fields, view(B & `ACCW_HW_MASK))
		u_accw_host.frame(32'hffff_ffff, 32);
		serial_mode = 1'b0;
		standby_pin_n = 1'b0;
		u_accw_host.par_write(32'h0);
		`CHK(cw, B)
		sw_mode = 1'b1;
		u_accw_host.tick(4);
		`CHK(cw, B)
	endtask
	task automatic t_pin_reset();
		pin_reset = 1'b1;
		u_accw_host.tick(6);
		`CHK(conv_abort, 1'b1)
		`CHK(cw, `ACCW_DEFAULT)
		pin_reset = 1'b0;
		u_accw_host.tick(4);
		`CHK(conv_abort, 1'b0)
	endtask
	// Frozen enable drops a parallel write; a later one lands
	task automatic t_freeze();
		clk_en = 1'b0;
		u_accw_host.tick(2);
		u_accw_host.par_write(32'h0000_0001);
		`CHK(cw, `ACCW_DEFAULT)
		clk_en = 1'b1;
		u_accw_host.tick(4);
		u_accw_host.par_write(32'h0040_0000);
		`CHK(cw, 32'h0040_0000)
	endtask
	// Main sequence
	initial begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		pin_reset = 1'b0;
		sw_mode = 1'b1;
		serial_mode = 1'b1;
		standby_pin_n = 1'b1;
		repeat (16) @(posedge clk);
		#1;
		arst_n = 1'b1;
		u_accw_host.tick(4);
		`CHK(cw, `ACCW_DEFAULT)
		`CHK(sdo, 1'b0)
		t_serial();
		t_parallel();
		t_hw();
		t_pin_reset();
		t_freeze();
		complete_run();
	end
endmodule
